//--- include/charger_regs_defs.vh
// Register map, field positions, reset values and link constants of the charger register bank
`ifndef CHARGER_REGS_DEFS_VH
`define CHARGER_REGS_DEFS_VH

// Register byte addresses
`define A_CTRL 8'h01
`define A_FV 8'h02
`define A_ID 8'h03
`define A_ID_ALT 8'h3B
`define A_ICHG 8'h04
`define A_WEAK 8'h05
`define A_SAFE 8'h06
`define A_MON 8'h10

// Reset values of the stored registers
`define R_CTRL 8'h30
`define R_FV 8'h0A
`define R_ICHG 8'h89
`define R_WEAK 8'h24
`define R_SAFE 8'h40

// Field positions
`define F_HZ 1
`define F_BOOST 0
`define F_FV_HI 7
`define F_FV_LO 2
`define F_PPOL 1
`define F_PEN 0
`define F_RST 7
`define F_IOC_HI 6
`define F_IOC_LO 4
`define F_IT_HI 2
`define F_IT_LO 0
`define F_VREG 6
`define F_IOL 5
`define F_WVOLT_HI 2
`define F_WVOLT_LO 0
`define F_ICAP_HI 6
`define F_ICAP_LO 4
`define F_VCAP_HI 3
`define F_VCAP_LO 0

// Float voltage scale in millivolts
`define FV_BASE_MV 13'd3500
`define FV_STEP_MV 13'd20

// Identification fields, values arbitrary
`define ID_MAKER 3'h5
`define ID_PART 3'h2
`define ID_REVISION 2'h1

// Serial slave address, value arbitrary
`define DEV_ADDR 7'h35

`endif

//--- hw/pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;

  // Level changes only where stages two and three agree
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end
    else if (ce_in)
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
    end
  end

  assign level_out = lvl_q;
endmodule
`default_nettype wire

//--- hw/charger_regs.v
// Charger configuration and status register bank behind a serial two-wire slave
//
// Summary of operation
// - Float voltage 3.5 V plus 20 mV steps
// - Identification readable at two addresses
// - Identification holds maker, variant, revision
// - Restore bit resets all except limits
// - Max charge current field, reset 0x89
// - Termination current field bits 2:0
// - Bit6 set turns auxiliary regulator off
// - Bit5 clear: current follows charge field
// - Bit5 set: fixed 22.1 mV sense target
// - Bit4 reads weak source regulation state
// - Weak source voltage field bits 2:0
// - Limits bit7 reads zero, reset 0x40
// - Current cap field bits 6:4
// - Voltage cap field bits 3:0
// - Monitor bit7 termination comparator
// - Monitor bit6 battery voltage comparator
// - Monitor bit5 linear precharge on
`include "charger_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module charger_regs (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n_out,
  input wire weak_source_active_in,
  input wire disable_pin_in,
  input wire termination_compare_in,
  input wire battery_voltage_compare_in,
  input wire linear_precharge_on_in,
  input wire [4:0] loop_status_in,
  output wire input_high_impedance_out,
  output wire boost_select_out,
  output wire [5:0] float_voltage_out,
  output wire [12:0] float_voltage_mv_out,
  output wire host_pin_polarity_out,
  output wire host_pin_enable_out,
  output wire [2:0] max_charge_current_out,
  output wire [2:0] termination_current_out,
  output wire aux_regulator_off_out,
  output wire fixed_sense_target_out,
  output wire [2:0] charge_current_code_out,
  output wire [2:0] weak_source_voltage_out,
  output wire [2:0] current_cap_out,
  output wire [3:0] voltage_cap_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Serial slave states
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_AACK = 9'h004;
  localparam [8:0] S_REG = 9'h008;
  localparam [8:0] S_RACK = 9'h010;
  localparam [8:0] S_WDAT = 9'h020;
  localparam [8:0] S_WACK = 9'h040;
  localparam [8:0] S_RDAT = 9'h080;
  localparam [8:0] S_MACK = 9'h100;

  wire scl_s;
  wire sda_s;
  wire [9:0] stat_s;
  reg scl_prev_q;
  reg sda_prev_q;
  reg [8:0] state_q;
  reg [2:0] cnt_q;
  reg done_q;
  reg rw_q;
  reg nack_q;
  reg [7:0] sh_q;
  reg [7:0] rd_q;
  reg [7:0] ptr_q;
  reg oe_n_q;
  reg sda_lo_q;
  reg [7:0] ctrl_q;
  reg [7:0] fv_q;
  reg [6:0] ichg_q;
  reg [2:0] weak_q;
  reg [6:0] safe_q;
  reg [12:0] fv_mv_q;
  reg [2:0] eff_cur_q;
  reg [2:0] weak_volt_q;

  // Reset images at full register width, sliced to the stored widths where used
  localparam [7:0] ICHG_RST = `R_ICHG;
  localparam [7:0] WEAK_RST = `R_WEAK;
  localparam [7:0] SAFE_RST = `R_SAFE;

  //////////////////////////////////////////////////////////////////////////////
  // Pin and status synchronisers
  pin_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_bus_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in({scl_in, sda_in}),
    .level_out({scl_s, sda_s})
  );

  pin_sync #(
    .W(10),
    .RST_VAL(10'h000)
  ) u_stat_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in({weak_source_active_in, disable_pin_in, termination_compare_in,
             battery_voltage_compare_in, linear_precharge_on_in, loop_status_in}),
    .level_out(stat_s)
  );

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // Read decode
  function [7:0] rd_map;
    input [7:0] a;
    begin
      case (a)
        `A_CTRL: rd_map = ctrl_q;
        `A_FV: rd_map = fv_q;
        `A_ID, `A_ID_ALT: rd_map = {`ID_MAKER, `ID_PART, `ID_REVISION};
        `A_ICHG: rd_map = {1'b1, ichg_q[6:4], 1'b1, ichg_q[2:0]};
        `A_WEAK: rd_map = {1'b0, weak_q[1:0], stat_s[9:8], weak_volt_q};
        `A_SAFE: rd_map = {1'b0, safe_q};
        `A_MON: rd_map = stat_s[7:0];
        default: rd_map = 8'h00;
      endcase
    end
  endfunction

  // Smaller of two current codes
  function [2:0] min3;
    input [2:0] a;
    input [2:0] b;
    begin
      min3 = (a < b) ? a : b;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave sequencer and register writes
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sh_q <= 8'h00;
      rd_q <= 8'hFF;
      ptr_q <= 8'h00;
      oe_n_q <= 1'b1;
      sda_lo_q <= 1'b0;
      ctrl_q <= `R_CTRL;
      fv_q <= `R_FV;
      ichg_q <= ICHG_RST[6:0];
      weak_q <= {1'b0, WEAK_RST[`F_VREG], WEAK_RST[`F_IOL]};
      weak_volt_q <= WEAK_RST[`F_WVOLT_HI:`F_WVOLT_LO];
      safe_q <= SAFE_RST[6:0];
    end
    else if (ce_in)
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      sda_lo_q <= 1'b0;
      if (start_c)
      begin
        state_q <= S_ADDR;
        cnt_q <= 3'h0;
        done_q <= 1'b0;
        oe_n_q <= 1'b1;
      end
      else if (stop_c)
      begin
        state_q <= S_IDLE;
        oe_n_q <= 1'b1;
      end
      else if (scl_rise)
      begin
        // Sample on the high phase
        sh_q <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 3'h1;
        done_q <= (cnt_q == 3'h7);
        if (state_q == S_MACK)
          nack_q <= sda_s;
      end
      else if (scl_fall)
      begin
        case (state_q)
          S_ADDR:
            if (done_q)
            begin
              done_q <= 1'b0;
              if (sh_q[7:1] == `DEV_ADDR)
              begin
                rw_q <= sh_q[0];
                oe_n_q <= 1'b0;
                state_q <= S_AACK;
              end
              else
                state_q <= S_IDLE;
            end
          S_AACK:
          begin
            cnt_q <= 3'h0;
            if (rw_q)
            begin
              // Bit 7 goes on the line now, the rest waits in the shifter
              {oe_n_q, rd_q} <= {rd_map(ptr_q), 1'b1};
              ptr_q <= ptr_q + 8'h01;
              state_q <= S_RDAT;
            end
            else
            begin
              oe_n_q <= 1'b1;
              state_q <= S_REG;
            end
          end
          S_REG:
            if (done_q)
            begin
              done_q <= 1'b0;
              ptr_q <= sh_q;
              oe_n_q <= 1'b0;
              state_q <= S_RACK;
            end
          S_RACK, S_WACK:
          begin
            cnt_q <= 3'h0;
            oe_n_q <= 1'b1;
            state_q <= S_WDAT;
          end
          S_WDAT:
            if (done_q)
            begin
              done_q <= 1'b0;
              oe_n_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= S_WACK;
              case (ptr_q)
                `A_CTRL: ctrl_q <= sh_q;
                `A_FV: fv_q <= sh_q;
                `A_ICHG:
                  if (sh_q[`F_RST])
                  begin
                    ctrl_q <= `R_CTRL;
                    fv_q <= `R_FV;
                    ichg_q <= ICHG_RST[6:0];
                    weak_q <= {1'b0, WEAK_RST[`F_VREG], WEAK_RST[`F_IOL]};
                    weak_volt_q <= WEAK_RST[`F_WVOLT_HI:`F_WVOLT_LO];
                  end
                  else
                    ichg_q <= {sh_q[6:4], 1'b1, sh_q[2:0]};
                `A_WEAK:
                begin
                  weak_q <= {1'b0, sh_q[`F_VREG], sh_q[`F_IOL]};
                  weak_volt_q <= sh_q[`F_WVOLT_HI:`F_WVOLT_LO];
                end
                `A_SAFE: safe_q <= sh_q[6:0];
                default: safe_q <= safe_q;
              endcase
            end
          S_RDAT:
            if (done_q)
            begin
              done_q <= 1'b0;
              oe_n_q <= 1'b1;
              state_q <= S_MACK;
            end
            else
            begin
              // Open-drain: release for one, pull for zero
              oe_n_q <= rd_q[7];
              rd_q <= {rd_q[6:0], 1'b1};
            end
          S_MACK:
          begin
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            if (nack_q)
            begin
              oe_n_q <= 1'b1;
              state_q <= S_IDLE;
            end
            else
            begin
              {oe_n_q, rd_q} <= {rd_map(ptr_q), 1'b1};
              ptr_q <= ptr_q + 8'h01;
              state_q <= S_RDAT;
            end
          end
          S_IDLE:
            oe_n_q <= 1'b1;
          default:
          begin
            oe_n_q <= 1'b1;
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Derived control values
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fv_mv_q <= 13'h0000;
      eff_cur_q <= 3'h0;
    end
    else if (ce_in)
    begin
      fv_mv_q <= `FV_BASE_MV + `FV_STEP_MV * {7'h00, fv_q[`F_FV_HI:`F_FV_LO]};
      eff_cur_q <= min3(ichg_q[`F_IOC_HI:`F_IOC_LO], safe_q[`F_ICAP_HI:`F_ICAP_LO]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign sda_out = sda_lo_q;
  assign sda_oe_n_out = oe_n_q;
  assign input_high_impedance_out = ctrl_q[`F_HZ];
  assign boost_select_out = ctrl_q[`F_BOOST];
  assign float_voltage_out = fv_q[`F_FV_HI:`F_FV_LO];
  assign float_voltage_mv_out = fv_mv_q;
  assign host_pin_polarity_out = fv_q[`F_PPOL];
  assign host_pin_enable_out = fv_q[`F_PEN];
  assign max_charge_current_out = ichg_q[`F_IOC_HI:`F_IOC_LO];
  assign termination_current_out = ichg_q[`F_IT_HI:`F_IT_LO];
  assign aux_regulator_off_out = weak_q[1];
  assign fixed_sense_target_out = weak_q[0];
  assign charge_current_code_out = eff_cur_q;
  assign weak_source_voltage_out = weak_volt_q;
  assign current_cap_out = safe_q[`F_ICAP_HI:`F_ICAP_LO];
  assign voltage_cap_out = safe_q[`F_VCAP_HI:`F_VCAP_LO];
endmodule
`default_nettype wire

//--- testbench/charger_regs_properties.sv
// Port-level checker for the charger register bank
`timescale 1ns/1ps
`default_nettype none
module charger_regs_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic input_high_impedance_out,
  input wire logic boost_select_out,
  input wire logic [5:0] float_voltage_out,
  input wire logic [12:0] float_voltage_mv_out,
  input wire logic [2:0] max_charge_current_out,
  input wire logic [2:0] termination_current_out,
  input wire logic [2:0] charge_current_code_out,
  input wire logic [2:0] current_cap_out,
  input wire logic [3:0] voltage_cap_out
);
  default clocking @(posedge clk_in);
  endclocking
  ////////////////////////////////////////////////////////////////////////////////
  float_scale_a:
    assert property (disable iff (rst_in) !$past(rst_in) |->
      float_voltage_mv_out == 13'hDAC + 13'h14 * $past(float_voltage_out)) else $error("float millivolts wrong");
  current_min_a:
    assert property (disable iff (rst_in) !$past(rst_in) |-> charge_current_code_out ==
      ($past(max_charge_current_out) < $past(current_cap_out) ? $past(max_charge_current_out) : $past(current_cap_out)))
    else $error("capped charge code wrong");
  reset_cfg_a:
    assert property (rst_in |=> max_charge_current_out == 3'h0 && termination_current_out == 3'h1 &&
      float_voltage_out == 6'h02) else $error("charge fields not at reset value");
  reset_lim_a:
    assert property (rst_in |=> current_cap_out == 3'h4 && voltage_cap_out == 4'h0 &&
      !input_high_impedance_out && !boost_select_out) else $error("limit fields not at reset value");
  bus_release_a:
    assert property (rst_in |=> sda_oe_n_out) else $error("data line held during reset");
  sda_zero_a:
    assert property (sda_out == 1'h0) else $error("data output not low");
  cfg_timing_a:
    assert property (disable iff (rst_in) !$past(rst_in) && ($changed(termination_current_out) ||
      $changed(voltage_cap_out)) |-> !scl_in) else $error("field changed while bus clock high");
  sda_edge_a:
    assert property (disable iff (rst_in) !$past(rst_in) && $changed(sda_oe_n_out) |->
      !scl_in && !$past(scl_in, 3)) else $error("data line moved near bus clock high");
endmodule
bind charger_regs charger_regs_properties chk (.clk_in, .rst_in, .scl_in, .sda_out, .sda_oe_n_out,
  .input_high_impedance_out, .boost_select_out, .float_voltage_out, .float_voltage_mv_out,
  .max_charge_current_out, .termination_current_out, .charge_current_code_out, .current_cap_out,
  .voltage_cap_out);
`default_nettype wire

//--- testbench/i2c_host_model.sv
// Two-wire bus host that programs the charger register bank
`include "charger_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter int H = 20
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out = 1'h1,
  output logic sda_low_out = 1'h0
);
  logic last_ack = 1'h1;
  int nacks = 0;
  // Waits whole system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Start or repeated start
  task automatic start();
    sda_low_out <= 1'h0;
    tick(H);
    scl_out <= 1'h1;
    tick(H);
    sda_low_out <= 1'h1;
    tick(H);
    scl_out <= 1'h0;
    tick(H);
  endtask
  // Stop, data rises with clock high
  task automatic stop();
    sda_low_out <= 1'h1;
    tick(H);
    scl_out <= 1'h1;
    tick(H);
    sda_low_out <= 1'h0;
    tick(H);
  endtask
  // Eight bits MSB first, then acknowledge bit; data moves only with clock low
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q);
    logic r;
    for (int i = 8; i >= 0; i--)
    begin
      sda_low_out <= (i > 0) ? !d[i-1] : !mack;
      tick(H);
      scl_out <= 1'h1;
      tick(H);
      r = sda_in;
      scl_out <= 1'h0;
      tick(4);
      if (i > 0)
        q[i-1] = r;
      else
        last_ack = r;
    end
  endtask
  // Byte that the slave must acknowledge
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    xfer(d, 1'h1, q);
    nacks += last_ack;
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send({`DEV_ADDR, 1'h0});
    send(a);
    send(d);
    stop();
  endtask
  // Register read, closed by a host refusal
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    send({`DEV_ADDR, 1'h0});
    send(a);
    start();
    send({`DEV_ADDR, 1'h1});
    xfer(8'hFF, 1'h1, d);
    stop();
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the charger register bank
`include "charger_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [9:0] stat = 10'h000;
  logic [7:0] rv [1:6] = '{8'h30, 8'h0A, 8'h00, 8'h89, 8'h24, 8'h40};
  logic [7:0] msk [1:6] = '{8'hFF, 8'hFF, 8'h00, 8'h77, 8'h67, 8'h7F};
  int failures = 0;
  int num_checks = 0;
  wire [43:0] outs;
  wire scl;
  wire host_low;
  wire sda_o;
  wire sda_oe_n;
  wire sda_line = !host_low && (sda_oe_n || sda_o);
  // Clock
  always #2 clk_in = ~clk_in;
  i2c_host_model host (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_low_out(host_low));
  charger_regs dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'h1), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .weak_source_active_in(stat[9]), .disable_pin_in(stat[8]),
    .termination_compare_in(stat[7]), .battery_voltage_compare_in(stat[6]),
    .linear_precharge_on_in(stat[5]), .loop_status_in(stat[4:0]), .input_high_impedance_out(outs[0]),
    .boost_select_out(outs[1]), .float_voltage_out(outs[7:2]), .float_voltage_mv_out(outs[20:8]),
    .host_pin_polarity_out(outs[21]), .host_pin_enable_out(outs[22]), .max_charge_current_out(outs[25:23]),
    .termination_current_out(outs[28:26]), .charge_current_code_out(outs[31:29]),
    .aux_regulator_off_out(outs[32]), .fixed_sense_target_out(outs[33]),
    .weak_source_voltage_out(outs[36:34]), .current_cap_out(outs[39:37]), .voltage_cap_out(outs[43:40]));
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input string n, input logic [43:0] e, input logic [43:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Expected read value of one address
  function automatic logic [7:0] rexp(input logic [7:0] a);
    case (a)
      8'h01, 8'h02, 8'h04, 8'h06: return rv[a[2:0]];
      8'h05: return rv[5] | {3'h0, stat[9:8], 3'h0};
      8'h03, 8'h3B: return {`ID_MAKER, `ID_PART, `ID_REVISION};
      8'h10: return stat[7:0];
      default: return 8'h00;
    endcase
  endfunction
  // Register access through the host, with the expected image kept alongside
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a == 8'h04 && d[7])
      rv = '{8'h30, 8'h0A, 8'h00, 8'h89, 8'h24, rv[6]};
    else if (a >= 8'h01 && a <= 8'h06 && a != 8'h03)
      rv[a[2:0]] = (d & msk[a[2:0]]) | (a == 8'h04 ? 8'h88 : 8'h00);
  endtask
  task automatic get(input logic [7:0] a);
    logic [7:0] q;
    host.rd(a, q);
    chk($sformatf("register %h", a), {36'h0, rexp(a)}, {36'h0, q});
  endtask
  task automatic check_outs();
    logic [5:0] fv;
    logic [2:0] m;
    logic [2:0] c;
    fv = rv[2][7:2];
    m = rv[4][6:4];
    c = rv[6][6:4];
    chk("outputs", {rv[6][3:0], c, rv[5][2:0], rv[5][5], rv[5][6], (m < c ? m : c), rv[4][2:0], m,
      rv[2][0], rv[2][1], 13'hDAC + 13'h14 * fv, fv, rv[1][0], rv[1][1]}, outs);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check_outs();
    for (int a = 1; a <= 6; a++)
      get(8'(a));
    $display("t_reset done");
  endtask
  task automatic t_fields();
    put(8'h01, 8'h33);
    put(8'h02, 8'hFF);
    put(8'h04, 8'h75);
    put(8'h05, 8'h47);
    put(8'h06, 8'hFF);
    for (int a = 1; a <= 6; a++)
      get(8'(a));
    check_outs();
    put(8'h06, 8'h2F);
    check_outs();
    $display("t_fields done");
  endtask
  task automatic t_restore();
    put(8'h04, 8'h80);
    for (int a = 1; a <= 6; a++)
      get(8'(a));
    check_outs();
    $display("t_restore done");
  endtask
  task automatic t_id();
    get(8'h3B);
    put(8'h03, 8'h00);
    get(8'h03);
    put(8'h10, 8'hFF);
    get(8'h20);
    $display("t_id done");
  endtask
  task automatic t_status();
    logic [7:0] q;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_in);
      stat <= i ? 10'h155 : 10'h3AA;
      get(8'h10);
      get(8'h05);
    end
    host.start();
    host.xfer(8'hA0, 1'h1, q);
    host.stop();
    chk("address refusal", 44'h1, {43'h0, host.last_ack});
    chk("missed acks", 44'h0, 44'(host.nacks));
    $display("t_status done");
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (8) @(posedge clk_in);
    t_reset();
    t_fields();
    t_restore();
    t_id();
    t_status();
    stop_test();
  end
  // Watchdog
  initial
  begin
    repeat (90000) @(posedge clk_in);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
